// ---- chain_diag_map.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the chain status block.
// Assumes: Included by its bare name; definitions only.
// Notes: Times are in their own unit; cycle counts are derived in the modules.
`ifndef CHAIN_DIAG_MAP_SVH
`define CHAIN_DIAG_MAP_SVH

`define CLK_HZ 40000000
`define REG_ERROR_DESCRIPTION 16'h0000
`define REG_GUARD_STATES_LOW 16'h0001
`define REG_GUARD_STATES_HIGH 16'h0002
`define REG_FAULT_POSITION 16'h0003
`define REG_CONFIGURED_SWITCH_COUNT 16'h0004
`define REG_WORDS 5
`define REG_RESET 16'h0000
`define ERR_LOOP_BIT 4
`define ERR_OVER_BIT 3
`define ERR_MISMATCH_BIT 2
`define ERR_FAIL_BIT 1
`define ERR_CONTACT_BIT 0
`define MAX_SWITCHES 6'h14
`define FN_READ_HOLDING 8'h03
`define FN_EXCEPTION_FLAG 8'h80
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define MAX_READ_QTY 16'h007D
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_57600 57600
`define BAUD_76800 76800
`define BAUD_115200 115200
`define BAUD_DEFAULT_SEL 3'h1
`define GAP_BITS 6'h27
`define INIT_TIME_MS 5000
`define DIAG_TIMEOUT_MS 5000
`define BLINK_TIME_MS 50

`endif

// ---- chain_diag_pkg.sv ----
// Purpose: Types shared by the chain status block and its serial line.
// Assumes: Numbers live in chain_diag_map.svh.
// Notes: Indicator colour code is {red, green}; orange lights both.
package chain_diag_pkg;
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_RUN = 2'b01,
      ST_ERROR = 2'b10
   } chain_state_e;
   typedef enum logic [1:0] {
      LED_OFF = 2'b00,
      LED_GREEN = 2'b01,
      LED_RED = 2'b10,
      LED_ORANGE = 2'b11
   } led_e;
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD = 2'b10
   } parity_e;
   typedef struct packed {
      logic [5:0] detected_count;
      logic [19:0] guard_closed;
      logic [4:0] fault_pos;
      logic loop_missing;
      logic switch_fail;
      logic cable_disc;
   } diag_frame_s;
endpackage

// ---- uart_line.sv ----
// Purpose: Half duplex serial byte line with run-time divisor and parity.
// Assumes: rx is already synchronised to clk.
// Notes: Without parity two stop bits are sent, as the line framing requires.
`timescale 1ns/1ps
`include "chain_diag_map.svh"
module uart_line import chain_diag_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Line settings
   input wire logic [12:0] bit_div,
   input wire parity_e parity,
   // Receive side
   input wire logic rx,
   output logic rx_stb,
   output logic [7:0] rx_byte,
   output logic rx_bad,
   output logic bit_tick,
   // Transmit side
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready,
   output logic tx_line,
   output logic tx_busy
);
   logic rx_act_q;
   logic [12:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [8:0] rx_sh_q;
   logic [12:0] tk_q;
   logic [12:0] tx_cnt_q;
   logic [3:0] tx_n_q;
   logic [9:0] tx_sh_q;
   wire no_par = (parity == PAR_NONE);
   wire [3:0] rx_last = no_par ? 4'h9 : 4'hA;
   wire [7:0] rx_data = no_par ? rx_sh_q[8:1] : rx_sh_q[7:0];
   wire par_ok = no_par | ((parity == PAR_ODD) == (^rx_sh_q));
   wire tx_par = (parity == PAR_ODD) ? ~(^tx_byte) : (^tx_byte);
   wire [9:0] tx_frame = {1'b1, (no_par ? 1'b1 : tx_par), tx_byte};
   assign tx_ready = ~tx_busy;
   assign bit_tick = (tk_q == 13'h0000);

   always_ff @(posedge clk) begin
      if (rst || tk_q == 13'h0000) begin
         tk_q <= bit_div - 13'h0001;
      end else begin
         tk_q <= tk_q - 13'h0001;
      end
   end

   always_ff @(posedge clk) begin
      rx_stb <= 1'b0;
      rx_bad <= 1'b0;
      if (rst) begin
         rx_act_q <= 1'b0;
         rx_cnt_q <= 13'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 9'h000;
         rx_byte <= 8'h00;
      end else if (!rx_act_q) begin
         if (!rx) begin
            rx_act_q <= 1'b1;
            rx_cnt_q <= bit_div >> 1;
            rx_bit_q <= 4'h0;
         end
      end else if (rx_cnt_q != 13'h0000) begin
         rx_cnt_q <= rx_cnt_q - 13'h0001;
      end else begin
         rx_cnt_q <= bit_div - 13'h0001;
         rx_bit_q <= rx_bit_q + 4'h1;
         if (rx_bit_q == 4'h0) begin
            rx_act_q <= ~rx;
         end else if (rx_bit_q < rx_last) begin
            rx_sh_q <= {rx, rx_sh_q[8:1]};
         end else begin
            rx_act_q <= 1'b0;
            rx_byte <= rx_data;
            rx_stb <= rx & par_ok;
            rx_bad <= ~(rx & par_ok);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_busy <= 1'b0;
         tx_line <= 1'b1;
         tx_cnt_q <= 13'h0000;
         tx_n_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
      end else if (!tx_busy) begin
         if (tx_valid) begin
            tx_busy <= 1'b1;
            tx_line <= 1'b0;
            tx_sh_q <= tx_frame;
            tx_n_q <= 4'hA;
            tx_cnt_q <= bit_div - 13'h0001;
         end
      end else if (tx_cnt_q != 13'h0000) begin
         tx_cnt_q <= tx_cnt_q - 13'h0001;
      end else if (tx_n_q == 4'h0) begin
         tx_busy <= 1'b0;
      end else begin
         tx_line <= tx_sh_q[0];
         tx_sh_q <= {1'b1, tx_sh_q[9:1]};
         tx_n_q <= tx_n_q - 4'h1;
         tx_cnt_q <= bit_div - 13'h0001;
      end
   end
endmodule

// ---- chain_diag_status.sv ----
// Purpose: Chain diagnostic status, read-only holding registers over a serial slave line,
//          chain-error contact and two status indicators.
// Assumes: DIAG_VALID and DIAG_FRAME come from the frame decoder on CLK.
// Notes:
// Overview of operation
// - Contact open during initialization and error state, closed otherwise.
// - Once open, contact stays open until reset; closes only when chain is consistent.
// - Diagnostic indicator orange init, green run, red error, off without data.
// - Error state on count mismatch, over twenty switches, missing terminator, fail, cut.
// - Bus indicator orange while detecting, blinks green good frame, red bad frame.
// - Only read holding registers, function 03h, is served.
// - Requests and replies use RTU framing with silent gaps and CRC.
// - Bit rate is detected during a five second initialization after reset; parity is hunted from frames after it.
// - Rates 9600 to 115200, default 19200; parity none, even or odd.
// - Word 1 holds guards one to sixteen; word 2 holds seventeen to twenty.
// - Word 3 low five bits give position of cut or failing switch.
// - Word 4 low five bits give the micro-switch switch count.
// - Error word bit 4 flags a missing loopback terminator.
// - Error word bit 3 flags more than twenty detected switches.
// - Error word bit 2 flags detected count differing from configured count.
// - Error word bit 1 flags failing switch, cable cut or bad transponder.
// - Error word bit 0 mirrors contact, one when closed; all bits reset zero.
// - Guard bits read one when closed; guard words read zero in error.
// - Each periodic diagnostic frame refreshes the register contents.
// - Slave address comes from the sixteen-position rotary selector.
`timescale 1ns/1ps
`include "chain_diag_map.svh"
module chain_diag_status import chain_diag_pkg::*; #(
   parameter int INIT_CYCLES = `INIT_TIME_MS * (`CLK_HZ / 1000),
   parameter int DIAG_TIMEOUT_CYCLES = `DIAG_TIMEOUT_MS * (`CLK_HZ / 1000),
   parameter int BLINK_CYCLES = `BLINK_TIME_MS * (`CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Chain diagnostics
   input wire logic DIAG_VALID,
   input wire diag_frame_s DIAG_FRAME,
   // Selector pins
   input wire logic [4:0] SWITCH_COUNT_SET,
   input wire logic [3:0] BUS_ADDR_SEL,
   // Serial bus
   input wire logic BUS_RX,
   output logic BUS_TX,
   output logic BUS_TX_EN,
   // Contact and indicators
   output logic CHAIN_ERR_CLOSED,
   output led_e DIAG_LED,
   output led_e BUS_LED
);
   localparam int TMAX = 2 ** 28;
   if (INIT_CYCLES < 1 || INIT_CYCLES >= TMAX || DIAG_TIMEOUT_CYCLES < 1 ||
       DIAG_TIMEOUT_CYCLES >= TMAX || BLINK_CYCLES < 1 || BLINK_CYCLES >= TMAX) begin : g_chk
      $error("Timer parameter out of range.");
   end
   localparam logic [27:0] INIT_LAST = 28'(INIT_CYCLES - 1);
   localparam logic [27:0] DIAG_LOAD = 28'(DIAG_TIMEOUT_CYCLES);
   localparam logic [27:0] BLINK_LOAD = 28'(BLINK_CYCLES);
   localparam logic [12:0] DIVS [6] = '{13'(`CLK_HZ / `BAUD_9600), 13'(`CLK_HZ / `BAUD_19200),
      13'(`CLK_HZ / `BAUD_38400), 13'(`CLK_HZ / `BAUD_57600), 13'(`CLK_HZ / `BAUD_76800),
      13'(`CLK_HZ / `BAUD_115200)};

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [2:0] pick_rate(input logic [15:0] low);
      logic [2:0] sel;
      sel = 3'h0;
      for (int i = 1; i < 6; i++) begin
         if (low < 16'((32'(DIVS[i - 1]) + 32'(DIVS[i])) / 2)) begin
            sel = 3'(i);
         end
      end
      return sel;
   endfunction

   logic [1:0] rx_sync_q;
   logic [4:0] cnt_meta_q, cnt_s_q;
   logic [3:0] adr_meta_q, adr_s_q;
   chain_state_e state_q, state_d;
   logic [27:0] init_cnt_q, fresh_q, blink_q;
   logic blink_red_q;
   logic seen_q;
   diag_frame_s diag_q;
   logic [2:0] baud_sel_q;
   logic [15:0] low_cnt_q, min_low_q;
   logic low_seen_q;
   parity_e par_q;
   logic par_lock_q;
   logic [7:0] rx_buf_q [8];
   logic [3:0] rx_len_q;
   logic frame_bad_q;
   logic [15:0] crc_rx_q, crc_tx_q;
   logic [5:0] gap_q;
   logic sending_q;
   logic [3:0] tx_idx_q;
   logic [7:0] rsp_code_q;
   logic [2:0] rsp_start_q, rsp_qty_q;
   logic rx_stb, rx_bad, bit_tick, tx_ready, tx_line, tx_busy;
   logic [7:0] rx_byte;
   wire rx_s = rx_sync_q[1];
   wire in_init = (state_q == ST_INIT);
   wire init_done = (init_cnt_q == INIT_LAST);
   // Indicators follow the next state, so they leave orange on the edge that closes the contact.
   wire next_init = (state_d == ST_INIT);

   // Error conditions are taken from the last frame and the live micro-switch setting.
   wire e_mism = seen_q && (diag_q.detected_count != {1'b0, cnt_s_q});
   wire e_over = (diag_q.detected_count > `MAX_SWITCHES);
   wire e_loop = diag_q.loop_missing;
   wire e_fail = diag_q.switch_fail | diag_q.cable_disc;
   wire any_err = e_mism | e_over | e_loop | e_fail;
   wire err_mode = any_err || (state_q == ST_ERROR);

   // Register words; unused upper bits are tied to zero.
   logic [15:0] reg_w [`REG_WORDS];
   assign reg_w[0] = {11'h000, e_loop, e_over, e_mism, e_fail, CHAIN_ERR_CLOSED};
   assign reg_w[1] = err_mode ? `REG_RESET : diag_q.guard_closed[15:0];
   assign reg_w[2] = err_mode ? `REG_RESET : {12'h000, diag_q.guard_closed[19:16]};
   assign reg_w[3] = {11'h000, diag_q.fault_pos};
   assign reg_w[4] = {11'h000, cnt_s_q};

   always_ff @(posedge CLK) begin
      rx_sync_q <= {rx_sync_q[0], BUS_RX};
      cnt_meta_q <= SWITCH_COUNT_SET;
      cnt_s_q <= cnt_meta_q;
      adr_meta_q <= BUS_ADDR_SEL;
      adr_s_q <= adr_meta_q;
   end

   // The error state never falls back to run, so an opened contact stays open until reset.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_INIT: if (init_done) state_d = any_err ? ST_ERROR : ST_RUN;
         ST_RUN: if (any_err) state_d = ST_ERROR;
         ST_ERROR: state_d = ST_ERROR;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_q <= ST_INIT;
         init_cnt_q <= 28'h0000000;
         CHAIN_ERR_CLOSED <= 1'b0;
      end else begin
         state_q <= state_d;
         init_cnt_q <= init_done ? init_cnt_q : init_cnt_q + 28'h0000001;
         CHAIN_ERR_CLOSED <= (state_d == ST_RUN);
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         diag_q <= '0;
         seen_q <= 1'b0;
         fresh_q <= 28'h0000000;
      end else if (DIAG_VALID) begin
         diag_q <= DIAG_FRAME;
         seen_q <= 1'b1;
         fresh_q <= DIAG_LOAD;
      end else if (fresh_q != 28'h0000000) begin
         fresh_q <= fresh_q - 28'h0000001;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         DIAG_LED <= LED_OFF;
      end else if (next_init) begin
         DIAG_LED <= LED_ORANGE;
      end else if (fresh_q == 28'h0000000) begin
         DIAG_LED <= LED_OFF;
      end else begin
         DIAG_LED <= err_mode ? LED_RED : LED_GREEN;
      end
   end

   // Rate detection takes the shortest low run seen during initialization as one bit time.
   // A noise spike on the line would therefore pick a rate that is too fast.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         low_cnt_q <= 16'h0000;
         min_low_q <= 16'hFFFF;
         low_seen_q <= 1'b0;
         baud_sel_q <= `BAUD_DEFAULT_SEL;
      end else if (in_init) begin
         if (!rx_s) begin
            low_cnt_q <= (low_cnt_q == 16'hFFFF) ? low_cnt_q : low_cnt_q + 16'h0001;
         end else if (low_cnt_q != 16'h0000) begin
            low_cnt_q <= 16'h0000;
            low_seen_q <= 1'b1;
            min_low_q <= (low_cnt_q < min_low_q) ? low_cnt_q : min_low_q;
         end
         if (init_done && low_seen_q) begin
            baud_sel_q <= pick_rate(min_low_q);
         end
      end
   end

   wire frame_end = (rx_len_q != 4'h0) && bit_tick && (gap_q == `GAP_BITS - 6'h01);
   wire [7:0] fn = rx_buf_q[1];
   wire crc_ok = (crc_rx_q == 16'h0000) && (rx_len_q >= 4'h4) && !frame_bad_q;
   wire ok_frame = crc_ok && (fn != `FN_READ_HOLDING || rx_len_q == 4'h8);
   wire hit = ok_frame && (rx_buf_q[0] == {4'h0, adr_s_q}) && !in_init && !sending_q;
   wire [15:0] q_start = {rx_buf_q[2], rx_buf_q[3]};
   wire [15:0] q_qty = {rx_buf_q[4], rx_buf_q[5]};
   wire [16:0] q_end = {1'b0, q_start} + {1'b0, q_qty};
   wire [7:0] exc_code = (fn != `FN_READ_HOLDING) ? `EXC_ILLEGAL_FUNCTION :
      (q_qty == 16'h0000 || q_qty > `MAX_READ_QTY) ? `EXC_ILLEGAL_VALUE :
      (q_end > 17'(`REG_WORDS)) ? `EXC_ILLEGAL_ADDRESS : 8'h00;

   // Parity hunts through none, even and odd on bad frames until one good frame locks it.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         par_q <= PAR_NONE;
         par_lock_q <= 1'b0;
      end else if (frame_end && !in_init) begin
         par_lock_q <= par_lock_q | ok_frame;
         if (!ok_frame && !par_lock_q) begin
            par_q <= (par_q == PAR_NONE) ? PAR_EVEN : (par_q == PAR_EVEN) ? PAR_ODD : PAR_NONE;
         end
      end
   end

   // Echo of our own reply on the half duplex pair is ignored while driving.
   wire rx_take = rx_stb && !BUS_TX_EN;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rx_len_q <= 4'h0;
         frame_bad_q <= 1'b0;
         crc_rx_q <= `CRC_INIT;
         gap_q <= 6'h00;
      end else if (frame_end) begin
         rx_len_q <= 4'h0;
         frame_bad_q <= 1'b0;
         crc_rx_q <= `CRC_INIT;
         gap_q <= 6'h00;
      end else if (rx_take) begin
         if (rx_len_q < 4'h8) begin
            rx_buf_q[rx_len_q[2:0]] <= rx_byte;
         end
         rx_len_q <= (rx_len_q == 4'h9) ? rx_len_q : rx_len_q + 4'h1;
         crc_rx_q <= crc_step(crc_rx_q, rx_byte);
         gap_q <= 6'h00;
      end else begin
         frame_bad_q <= frame_bad_q | (rx_bad && !BUS_TX_EN);
         gap_q <= (bit_tick && rx_len_q != 4'h0) ? gap_q + 6'h01 : gap_q;
      end
   end

   wire rsp_exc = (rsp_code_q != 8'h00);
   wire [3:0] body_len = rsp_exc ? 4'h3 : 4'h3 + {rsp_qty_q, 1'b0};
   wire [3:0] data_k = tx_idx_q - 4'h3;
   wire [2:0] data_reg = rsp_start_q + data_k[3:1];
   wire [15:0] data_word = (data_reg < 3'h5) ? reg_w[data_reg] : `REG_RESET;
   wire [7:0] tx_byte = (tx_idx_q == 4'h0) ? {4'h0, adr_s_q} :
      (tx_idx_q == 4'h1) ? (rsp_exc ? (`FN_READ_HOLDING | `FN_EXCEPTION_FLAG) : `FN_READ_HOLDING) :
      (tx_idx_q == 4'h2) ? (rsp_exc ? rsp_code_q : {4'h0, rsp_qty_q, 1'b0}) :
      (tx_idx_q < body_len) ? (data_k[0] ? data_word[7:0] : data_word[15:8]) :
      (tx_idx_q == body_len) ? crc_tx_q[7:0] : crc_tx_q[15:8];
   wire tx_go = sending_q && tx_ready;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sending_q <= 1'b0;
         tx_idx_q <= 4'h0;
         crc_tx_q <= `CRC_INIT;
         rsp_code_q <= 8'h00;
         rsp_start_q <= 3'h0;
         rsp_qty_q <= 3'h0;
         BUS_TX_EN <= 1'b0;
      end else begin
         BUS_TX_EN <= sending_q || tx_busy;
         if (frame_end && hit) begin
            sending_q <= 1'b1;
            tx_idx_q <= 4'h0;
            crc_tx_q <= `CRC_INIT;
            rsp_code_q <= exc_code;
            rsp_start_q <= q_start[2:0];
            rsp_qty_q <= q_qty[2:0];
         end else if (tx_go) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q < body_len) begin
               crc_tx_q <= crc_step(crc_tx_q, tx_byte);
            end
            if (tx_idx_q == body_len + 4'h1) begin
               sending_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         blink_q <= 28'h0000000;
         blink_red_q <= 1'b0;
         BUS_LED <= LED_OFF;
      end else begin
         if (frame_end) begin
            blink_q <= BLINK_LOAD;
            blink_red_q <= ~ok_frame;
         end else if (blink_q != 28'h0000000) begin
            blink_q <= blink_q - 28'h0000001;
         end
         if (next_init) begin
            BUS_LED <= LED_ORANGE;
         end else if (blink_q != 28'h0000000) begin
            BUS_LED <= blink_red_q ? LED_RED : LED_GREEN;
         end else begin
            BUS_LED <= LED_OFF;
         end
      end
   end

   assign BUS_TX = tx_line;

   uart_line u_line (
      .clk(CLK),
      .rst(SYS_RST),
      .bit_div(DIVS[baud_sel_q]),
      .parity(par_q),
      .rx(rx_s),
      .rx_stb(rx_stb),
      .rx_byte(rx_byte),
      .rx_bad(rx_bad),
      .bit_tick(bit_tick),
      .tx_valid(sending_q),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready),
      .tx_line(tx_line),
      .tx_busy(tx_busy)
   );
endmodule

// ---- chain_diag_props.sv ----
// Purpose: Port assertions for the chain status block.
// Assumes: One clock domain; synchronous reset.
// Notes: Small latency windows allow for the register stages inside the block.
`timescale 1ns/1ps
module chain_diag_props import chain_diag_pkg::*; #(
   parameter int INIT_CYCLES = 2000,
   parameter int DIAG_TIMEOUT_CYCLES = 3000,
   parameter int BLINK_CYCLES = 50
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Chain diagnostics
   input wire logic DIAG_VALID,
   input wire diag_frame_s DIAG_FRAME,
   // Serial bus
   input wire logic BUS_TX,
   input wire logic BUS_TX_EN,
   // Contact and indicators
   input wire logic CHAIN_ERR_CLOSED,
   input wire led_e DIAG_LED,
   input wire led_e BUS_LED
);
   int since_q;
   logic seen_closed_q;
   logic reopened_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         since_q <= 0;
         seen_closed_q <= 1'h0;
         reopened_q <= 1'h0;
      end else begin
         since_q <= (since_q < INIT_CYCLES) ? since_q + 1 : since_q;
         seen_closed_q <= seen_closed_q | CHAIN_ERR_CLOSED;
         reopened_q <= reopened_q | (seen_closed_q & ~CHAIN_ERR_CLOSED);
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_release;
      $fell(SYS_RST);
   endsequence
   sequence s_fault;
      DIAG_VALID && DIAG_LED != LED_ORANGE && (DIAG_FRAME.loop_missing ||
         DIAG_FRAME.switch_fail || DIAG_FRAME.cable_disc || DIAG_FRAME.detected_count > 6'h14);
   endsequence
   property p_init_leds;
      s_release |-> ##[1:2] (DIAG_LED == LED_ORANGE && BUS_LED == LED_ORANGE);
   endproperty
   a_init_leds: assert property (p_init_leds) else $error("Indicators not orange after reset");
   property p_init_open;
      CHAIN_ERR_CLOSED |-> since_q >= INIT_CYCLES - 4;
   endproperty
   a_init_open: assert property (p_init_open) else $error("Contact closed during init");
   property p_orange_open;
      DIAG_LED == LED_ORANGE |-> !CHAIN_ERR_CLOSED;
   endproperty
   a_orange_open: assert property (p_orange_open) else $error("Contact closed while orange");
   property p_red_open;
      DIAG_LED == LED_RED |=> !CHAIN_ERR_CLOSED;
   endproperty
   a_red_open: assert property (p_red_open) else $error("Contact closed in error");
   property p_sticky;
      reopened_q |-> !CHAIN_ERR_CLOSED;
   endproperty
   a_sticky: assert property (p_sticky) else $error("Contact closed again");
   property p_fault_open;
      s_fault |-> ##[1:4] !CHAIN_ERR_CLOSED;
   endproperty
   a_fault_open: assert property (p_fault_open) else $error("Fault left contact closed");
   property p_fault_red;
      s_fault |-> ##[1:4] DIAG_LED == LED_RED;
   endproperty
   a_fault_red: assert property (p_fault_red) else $error("Fault not shown red");
   property p_tx_idle;
      !BUS_TX_EN |-> BUS_TX;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("Line not idle high");
   property p_reply_blink;
      $rose(BUS_TX_EN) |-> BUS_LED == LED_GREEN;
   endproperty
   a_reply_blink: assert property (p_reply_blink) else $error("No green blink on reply");
   property p_no_init_reply;
      BUS_TX_EN |-> BUS_LED != LED_ORANGE;
   endproperty
   a_no_init_reply: assert property (p_no_init_reply) else $error("Reply during init");
endmodule
bind chain_diag_status chain_diag_props #(.INIT_CYCLES(INIT_CYCLES),
   .DIAG_TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) props (
   .CLK(CLK), .SYS_RST(SYS_RST), .DIAG_VALID(DIAG_VALID), .DIAG_FRAME(DIAG_FRAME),
   .BUS_TX(BUS_TX), .BUS_TX_EN(BUS_TX_EN), .CHAIN_ERR_CLOSED(CHAIN_ERR_CLOSED),
   .DIAG_LED(DIAG_LED), .BUS_LED(BUS_LED)
);

// ---- bus_master_model.sv ----
// Purpose: Serial bus master issuing register reads.
// Assumes: Called at a falling clock edge; BIT cycles per bit.
// Notes: The line rests high between frames, as the bus bias holds it.
`timescale 1ns/1ps
module bus_master_model #(
   parameter int BIT = 347
) (
   // Clock
   input wire logic clk,
   // Serial lines
   output logic rx_line,
   input wire logic tx_line,
   input wire logic tx_en
);
   logic [7:0] rsp [0:7];
   int got;
   initial rx_line = 1'h1;
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   // One low run of a bit time is enough for the device to pick this rate.
   task automatic probe();
      rx_line = 1'h0;
      repeat (BIT) @(negedge clk);
      rx_line = 1'h1;
   endtask
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] bits;
      bits = {2'h3, b, 1'h0};
      for (int i = 0; i < 11; i++) begin
         rx_line = bits[i];
         repeat (BIT) @(negedge clk);
      end
   endtask
   task automatic read_reg(input logic [7:0] addr, input logic [15:0] start, input int n);
      logic [7:0] f [0:7];
      logic [15:0] c;
      int w;
      f = '{addr, 8'h03, start[15:8], start[7:0], 8'h00, 8'h01, 8'h00, 8'h00};
      c = 16'hFFFF;
      for (int i = 0; i < 6; i++) c = crc_step(c, f[i]);
      f[6] = c[7:0];
      f[7] = c[15:8];
      for (int i = 0; i < 8; i++) send_byte(f[i]);
      got = 0;
      for (int k = 0; k < n; k++) begin
         w = 0;
         while (tx_line !== 1'h0 && w < 60 * BIT) begin
            @(negedge clk);
            w++;
         end
         repeat (BIT / 2) @(negedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            rsp[k][i] = tx_line;
         end
         repeat (BIT) @(negedge clk);
         if (w < 60 * BIT && tx_line === 1'h1 && tx_en === 1'h1) got++;
      end
   endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the chain status block.
// Assumes: Shortened init, timeout and blink counts; bus at 115200 bit/s.
// Notes: One bus read only, since a serial transfer costs tens of thousands of cycles.
`timescale 1ns/1ps
module tb_top import chain_diag_pkg::*; ;
   localparam int INIT = 2000;
   localparam int BIT = 347;
   logic clk;
   logic rst;
   logic diag_valid;
   diag_frame_s frame;
   logic [4:0] count_set;
   logic [3:0] addr_sel;
   logic bus_rx;
   logic bus_tx;
   logic bus_tx_en;
   logic closed;
   led_e diag_led;
   led_e bus_led;
   int failures;
   int tests_run;
   always #12.5 clk = ~clk;
   chain_diag_status #(.INIT_CYCLES(INIT), .DIAG_TIMEOUT_CYCLES(3000), .BLINK_CYCLES(50)) DUT (
      .CLK(clk), .SYS_RST(rst), .DIAG_VALID(diag_valid), .DIAG_FRAME(frame),
      .SWITCH_COUNT_SET(count_set), .BUS_ADDR_SEL(addr_sel), .BUS_RX(bus_rx),
      .BUS_TX(bus_tx), .BUS_TX_EN(bus_tx_en), .CHAIN_ERR_CLOSED(closed),
      .DIAG_LED(diag_led), .BUS_LED(bus_led)
   );
   bus_master_model #(.BIT(BIT)) master (
      .clk(clk), .rx_line(bus_rx), .tx_line(bus_tx), .tx_en(bus_tx_en)
   );
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic restart();
      @(negedge clk);
      rst = 1'h1;
      repeat (20) @(negedge clk);
      check(closed, 1'h0);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      check(diag_led, LED_ORANGE);
      check(bus_led, LED_ORANGE);
      master.probe();
      repeat (INIT - BIT - 20) @(negedge clk);
      check(closed, 1'h0);
      repeat (30) @(negedge clk);
   endtask
   task automatic diag(input logic [5:0] cnt, input logic [19:0] guards, input logic [2:0] err);
      frame = {cnt, guards, 5'h03, err};
      diag_valid = 1'h1;
      @(negedge clk);
      diag_valid = 1'h0;
      repeat (6) @(negedge clk);
   endtask
   task automatic t_init_run();
      restart();
      check(closed, 1'h1);
      check(diag_led, LED_OFF);
      diag(6'h05, 20'h0001B, 3'h0);
      check(diag_led, LED_GREEN);
      count_set = 5'h04;
      repeat (8) @(negedge clk);
      check(closed, 1'h0);
      check(diag_led, LED_RED);
      count_set = 5'h05;
      diag(6'h05, 20'h0001B, 3'h0);
      check(closed, 1'h0);
      $display("Init and run test done");
   endtask
   task automatic t_faults();
      logic [8:0] cases [0:3];
      cases = '{{6'h15, 3'h0}, {6'h05, 3'h4}, {6'h05, 3'h2}, {6'h05, 3'h1}};
      for (int i = 0; i < 4; i++) begin
         count_set = cases[i][7:3];
         restart();
         check(closed, 1'h1);
         diag(cases[i][8:3], 20'h0001F, cases[i][2:0]);
         check(closed, 1'h0);
         check(diag_led, LED_RED);
      end
      $display("Fault test done");
   endtask
   task automatic t_bus();
      logic [7:0] exp [0:6];
      logic [15:0] c;
      restart();
      diag(6'h15, 20'h00000, 3'h6);
      fork
         master.read_reg(8'h0A, 16'h0000, 7);
         begin
            wait (bus_tx_en === 1'h1);
            @(negedge clk);
            check(bus_led, LED_GREEN);
         end
      join
      exp = '{8'h0A, 8'h03, 8'h02, 8'h00, 8'h1E, 8'h00, 8'h00};
      c = 16'hFFFF;
      for (int i = 0; i < 5; i++) c = master.crc_step(c, exp[i]);
      exp[5] = c[7:0];
      exp[6] = c[15:8];
      check(master.got, 16'h0007);
      for (int i = 0; i < 7; i++) check(master.rsp[i], exp[i]);
      $display("Bus read test done");
   endtask
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      diag_valid = 1'h0;
      frame = '0;
      count_set = 5'h05;
      addr_sel = 4'hA;
      failures = 0;
      tests_run = 0;
      t_init_run();
      t_faults();
      t_bus();
      end_sim();
   end
   // The full run needs about 82000 cycles; this leaves a margin before cutting a hang.
   initial begin
      repeat (98000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule
